// ### hw/hrlp_pkg.sv
package hrlp_pkg;

    // ========================================================
    // Character codes
    // ========================================================
    localparam logic [7:0] PARITY_MASK = 8'h7F;
    localparam logic [7:0] CH_SEMI     = 8'h3B;
    localparam logic [7:0] CH_CR       = 8'h0D;
    localparam logic [7:0] CH_LF       = 8'h0A;
    localparam logic [7:0] CH_ACK      = 8'h2A;
    localparam logic [7:0] NAK_CHAR    = 8'h48;
    localparam logic [7:0] NAK_COUNT   = 8'h4B;
    localparam logic [7:0] NAK_ACHK    = 8'h4C;
    localparam logic [7:0] NAK_RCHK    = 8'h4D;
    localparam logic [7:0] NAK_TMO     = 8'h4E;
    localparam logic [7:0] NAK_RECS    = 8'h4F;
    localparam logic [7:0] NAK_ANY     = 8'h55;
    localparam logic [7:0] NAK_NONE    = 8'h00;

    // ========================================================
    // Record layout
    // ========================================================
    localparam logic [9:0] COUNT_DIGITS = 10'h001;
    localparam logic [9:0] ADDR_DIGITS  = 10'h003;
    localparam logic [9:0] ACHK_DIGITS  = 10'h001;
    localparam logic [9:0] RCHK_DIGITS  = 10'h004;
    localparam logic [7:0] MAX_BYTES    = 8'h20;
    localparam logic [15:0] ADDR_MAX_BASE = 16'h1FFF;
    localparam logic [15:0] ADDR_MAX_EXP  = 16'h7FFF;

    // ========================================================
    // Timing
    // ========================================================
    localparam int unsigned LINK_BAUD_MAX    = 600;
    localparam int unsigned LINK_DELAY_MAX_S = 3;
    localparam logic [63:0] CLK_HZ           = 64'd250_000_000;
    localparam logic [63:0] IDLE_TMO_S       = 64'd15;
    localparam logic [63:0] IDLE_TMO_CYC     = IDLE_TMO_S * CLK_HZ;
    localparam logic [1:0]  DEAD_TMO_COUNT   = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_COUNT,
        ST_ADDR,
        ST_ACHK,
        ST_BODY
    } hrlp_state_t;

endpackage

// ### hw/hrlp_hexdec.sv
`timescale 1ns/100ps
module hrlp_hexdec (
    input  wire logic [6:0] CHAR_I,
    output logic            IS_HEX_O,
    output logic [3:0]      NIB_O
);
    // Upper-case digits only, as the senders produce them
    always_comb begin
        IS_HEX_O = 1'b1;
        NIB_O    = 4'h0;
        if (CHAR_I >= 7'h30 && CHAR_I <= 7'h39) begin
            NIB_O = 4'(CHAR_I - 7'h30);
        end else if (CHAR_I >= 7'h41 && CHAR_I <= 7'h46) begin
            NIB_O = 4'(CHAR_I - 7'h37);
        end else begin
            IS_HEX_O = 1'b0;
        end
    end
endmodule // hrlp_hexdec

// ### hw/hrlp_buf.sv
`timescale 1ns/100ps
module hrlp_buf #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 2
) (
    input  wire logic             CLK_I,
    input  wire logic             RST_N_I,
    input  wire logic             IN_VALID_I,
    output logic                  IN_READY_O,
    input  wire logic [WIDTH-1:0] IN_DATA_I,
    output logic                  OUT_VALID_O,
    input  wire logic             OUT_READY_I,
    output logic      [WIDTH-1:0] OUT_DATA_O
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } hrlp_buf_st_t;

    hrlp_buf_st_t s_r, s_nxt;
    logic         wr;
    logic         rd;

    assign IN_READY_O  = (s_r.cnt != (AW+1)'(DEPTH));
    assign OUT_VALID_O = (s_r.cnt != '0);
    assign OUT_DATA_O  = s_r.mem[s_r.rp];

    always_comb begin
        s_nxt = s_r;
        wr    = IN_VALID_I & IN_READY_O;
        rd    = OUT_VALID_O & OUT_READY_I;
        if (wr) begin
            s_nxt.mem[s_r.wp] = IN_DATA_I;
            s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
        end
        if (rd) begin
            s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule // hrlp_buf

// ### hw/hrlp_rx.sv
`timescale 1ns/100ps
// Functional notes
// - Characters carry eight bits; top bit sent zero, ignored on receipt.
// - One start and one stop bit, handled by the UART.
// - No flow-control lines; only transmit, receive and ground.
// - Bit rate for this protocol at most 600 baud.
// - Tolerate three seconds one-way delay without declaring link failure.
// - Full-duplex link; acknowledgements travel on the independent line.
// - Each byte has a 16-bit address; rewrites replace earlier values.
// - Accept addresses up to 1FFF, or 7FFF with expanded memory.
// - A byte travels as two hex digits, high nibble first.
// - A data record holds one to thirty-two bytes.
// - First byte at start address, following bytes at consecutive ones.
// - Record starts with semicolon, two-digit count, four-digit address.
// - Then a two-digit address check, then the data digit pairs.
// - Then a four-digit check over all earlier record bytes but the address check.
// - Carriage return terminates every record.
// - One optional line feed after the return is accepted silently.
// - No byte is written unless the address check verified.
// - End record has zero count and distinct record total as address.
// - Compare end record total with own count; flag any mismatch.
// - Address check sums the six count and address nibbles.
// - Record check is a 16-bit sum of count, address, data bytes.
// - Answer asterisk for good records, another character otherwise.
module hrlp_rx
    import hrlp_pkg::*;
#(
    parameter logic [31:0] TMO_CYC  = IDLE_TMO_CYC[31:0],
    parameter int          BUF_DEPTH = 2
) (
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        UART_RX_VALID_I,
    output logic             UART_RX_READY_O,
    input  wire logic [7:0]  UART_RX_DATA_I,
    input  wire logic        UART_RX_ERR_I,
    output logic             UART_TX_VALID_O,
    input  wire logic        UART_TX_READY_I,
    output logic      [7:0]  UART_TX_DATA_O,
    output logic             MEM_VALID_O,
    input  wire logic        MEM_READY_I,
    output logic      [15:0] MEM_ADDR_O,
    output logic      [7:0]  MEM_DATA_O,
    input  wire logic        MEM_EXPANDED_I,
    output logic             DONE_O,
    output logic             REC_COUNT_ERR_O,
    output logic             LINK_DEAD_O
);
    // ========================================================
    // State
    // ========================================================
    typedef struct packed {
        hrlp_state_t st;
        logic [9:0]  dcnt;
        logic [7:0]  cnt;
        logic [15:0] addr;
        logic [7:0]  nsum;
        logic [15:0] rsum;
        logic [15:0] tail;
        logic [3:0]  hi;
        logic [7:0]  widx;
        logic [15:0] last_wa;
        logic [7:0]  nak;
        logic [7:0]  ack_char;
        logic        tx_pend;
        logic [15:0] recs;
        logic        armed;
        logic [31:0] tmo;
        logic [1:0]  tmo_n;
        logic        dead;
        logic        done;
        logic        cnt_err;
        logic        exp_s1;
        logic        exp_s2;
    } hrlp_rx_st_t;

    hrlp_rx_st_t s_r, s_nxt;
    logic        take;
    logic        push;
    logic [23:0] push_data;
    logic        buf_ready;
    logic [7:0]  ch;
    logic        is_hex;
    logic [3:0]  nib;
    logic [7:0]  byte_v;
    logic [15:0] waddr;
    logic [15:0] addr_lim;
    logic [9:0]  exp_dig;
    logic [7:0]  res;

    assign ch = UART_RX_DATA_I & PARITY_MASK;

    hrlp_hexdec u_hex (
        .CHAR_I   (ch[6:0]),
        .IS_HEX_O (is_hex),
        .NIB_O    (nib)
    );

    // Ack waits for the UART; stalling the receive side is safe
    // because a record only ends at the return character
    assign UART_RX_READY_O = buf_ready & ~s_r.tx_pend;
    assign UART_TX_VALID_O = s_r.tx_pend;
    assign UART_TX_DATA_O  = s_r.ack_char & PARITY_MASK;
    assign DONE_O          = s_r.done;
    assign REC_COUNT_ERR_O = s_r.cnt_err;
    assign LINK_DEAD_O     = s_r.dead;

    // ========================================================
    // Record parser
    // ========================================================
    always_comb begin
        s_nxt     = s_r;
        take      = UART_RX_VALID_I & UART_RX_READY_O;
        push      = 1'b0;
        push_data = '0;
        byte_v    = {s_r.hi, nib};
        waddr     = s_r.addr + {8'h00, s_r.widx};
        addr_lim  = s_r.exp_s2 ? ADDR_MAX_EXP : ADDR_MAX_BASE;
        exp_dig   = {1'b0, s_r.cnt, 1'b0} + 10'h004;
        res       = NAK_NONE;
        s_nxt.exp_s1 = MEM_EXPANDED_I;
        s_nxt.exp_s2 = s_r.exp_s1;

        if (s_r.tx_pend && UART_TX_READY_I) begin
            s_nxt.tx_pend = 1'b0;
        end

        // Idle and intra-record watchdog, well above the link delay
        if (take) begin
            s_nxt.tmo = '0;
        end else if ((s_r.armed || s_r.st != ST_IDLE) && !s_r.tx_pend
                     && !s_r.dead) begin
            s_nxt.tmo = s_r.tmo + 32'h1;
        end

        if (take && !s_r.dead) begin
            if (s_r.st == ST_IDLE) begin
                // Line feeds and other filler between records ignored
                if (ch == CH_SEMI) begin
                    s_nxt.st    = ST_COUNT;
                    s_nxt.dcnt  = '0;
                    s_nxt.nsum  = '0;
                    s_nxt.widx  = '0;
                    s_nxt.nak   = UART_RX_ERR_I ? NAK_CHAR : NAK_NONE;
                    s_nxt.done  = 1'b0;
                    s_nxt.tmo_n = '0;
                end
            end else if (ch == CH_CR) begin
                if (s_r.nak != NAK_NONE) begin
                    res = s_r.nak;
                end else if (s_r.st != ST_BODY || s_r.dcnt != exp_dig) begin
                    res = NAK_COUNT;
                end else if (s_r.tail != s_r.rsum) begin
                    res = NAK_RCHK;
                end else if (s_r.cnt != 8'h00) begin
                    res = CH_ACK;
                    s_nxt.recs = s_r.recs + 16'h1;
                end else if (s_r.addr == s_r.recs) begin
                    res = CH_ACK;
                    s_nxt.done = 1'b1;
                end else begin
                    res = NAK_RECS;
                    s_nxt.cnt_err = 1'b1;
                end
                s_nxt.ack_char = res;
                s_nxt.tx_pend  = 1'b1;
                s_nxt.st       = ST_IDLE;
                s_nxt.armed    = 1'b1;
            end else if (UART_RX_ERR_I || !is_hex) begin
                if (s_r.nak == NAK_NONE) begin
                    s_nxt.nak = NAK_CHAR;
                end
            end else begin
                s_nxt.dcnt = s_r.dcnt + 10'h001;
                case (s_r.st)
                    ST_COUNT: begin
                        s_nxt.cnt  = {s_r.cnt[3:0], nib};
                        s_nxt.nsum = s_r.nsum + {4'h0, nib};
                        if (s_r.dcnt == COUNT_DIGITS) begin
                            s_nxt.st   = ST_ADDR;
                            s_nxt.dcnt = '0;
                            if ({s_r.cnt[3:0], nib} > MAX_BYTES
                                && s_r.nak == NAK_NONE) begin
                                s_nxt.nak = NAK_COUNT;
                            end
                        end
                    end
                    ST_ADDR: begin
                        s_nxt.addr = {s_r.addr[11:0], nib};
                        s_nxt.nsum = s_r.nsum + {4'h0, nib};
                        if (s_r.dcnt == ADDR_DIGITS) begin
                            s_nxt.st   = ST_ACHK;
                            s_nxt.dcnt = '0;
                        end
                    end
                    ST_ACHK: begin
                        s_nxt.hi = nib;
                        if (s_r.dcnt == ACHK_DIGITS) begin
                            s_nxt.st   = ST_BODY;
                            s_nxt.dcnt = '0;
                            s_nxt.tail = '0;
                            s_nxt.rsum = {8'h00, s_r.cnt}
                                       + {8'h00, s_r.addr[15:8]}
                                       + {8'h00, s_r.addr[7:0]};
                            if (byte_v != s_r.nsum
                                && s_r.nak == NAK_NONE) begin
                                s_nxt.nak = NAK_ACHK;
                            end
                        end
                    end
                    ST_BODY: begin
                        s_nxt.tail = {s_r.tail[11:0], nib};
                        if (!s_r.dcnt[0]) begin
                            s_nxt.hi = nib;
                        end else if (s_r.widx < s_r.cnt) begin
                            s_nxt.rsum = s_r.rsum + {8'h00, byte_v};
                            s_nxt.widx = s_r.widx + 8'h01;
                            if (waddr > addr_lim) begin
                                if (s_r.nak == NAK_NONE) begin
                                    s_nxt.nak = NAK_ANY;
                                end
                            end else if (s_r.nak == NAK_NONE) begin
                                push      = 1'b1;
                                push_data = {waddr, byte_v};
                                s_nxt.last_wa = waddr;
                            end
                        end
                    end
                    default: begin
                        s_nxt.st = ST_IDLE;
                    end
                endcase
            end
        end

        if (s_r.tmo == TMO_CYC - 32'h1 && !take) begin
            s_nxt.tmo      = '0;
            s_nxt.st       = ST_IDLE;
            s_nxt.ack_char = NAK_TMO;
            s_nxt.tx_pend  = 1'b1;
            s_nxt.tmo_n    = s_r.tmo_n + 2'h1;
            if (s_r.tmo_n + 2'h1 == DEAD_TMO_COUNT) begin
                s_nxt.dead    = 1'b1;
                s_nxt.tx_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ========================================================
    // Write buffer
    // ========================================================
    hrlp_buf #(
        .WIDTH (24),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .CLK_I       (CLK_I),
        .RST_N_I     (RST_N_I),
        .IN_VALID_I  (push),
        .IN_READY_O  (buf_ready),
        .IN_DATA_I   (push_data),
        .OUT_VALID_O (MEM_VALID_O),
        .OUT_READY_I (MEM_READY_I),
        .OUT_DATA_O  ({MEM_ADDR_O, MEM_DATA_O})
    );

    // ========================================================
    // Checks
    // ========================================================
    a_tx_top_zero: assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        UART_TX_VALID_O |-> !UART_TX_DATA_O[7])
        else $error("ack char top bit set");
    a_ack_after_cr: assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        $rose(UART_TX_VALID_O) && UART_TX_DATA_O != NAK_TMO
        |-> $past(take) && $past(ch) == CH_CR)
        else $error("answer without terminator");
    a_write_range: assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        push |-> push_data[23:8] <= addr_lim)
        else $error("write beyond installed memory");
    a_write_gated: assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        push |-> s_r.st == ST_BODY && s_r.nak == NAK_NONE)
        else $error("write before address check verified");
    a_tx_hold: assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        UART_TX_VALID_O && !UART_TX_READY_I
        |=> UART_TX_VALID_O && $stable(UART_TX_DATA_O))
        else $error("ack char dropped while stalled");
    a_rec_count: assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        s_r.recs != $past(s_r.recs)
        |-> s_r.recs == $past(s_r.recs) + 16'h1
            && UART_TX_DATA_O == CH_ACK)
        else $error("record count moved without ack");
    a_cnt_err_nak: assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        $rose(REC_COUNT_ERR_O) |-> UART_TX_DATA_O == NAK_RECS)
        else $error("count mismatch not answered");
    a_wr_stride: assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        push |-> push_data[23:8] == ((s_r.widx == 8'h00) ? s_r.addr
                                     : s_r.last_wa + 16'h1))
        else $error("bytes not at consecutive addresses");
    a_bytes_max: assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        push |-> s_r.widx < MAX_BYTES)
        else $error("more than max bytes written");
    a_dead_sticky: assert property (
        @(posedge CLK_I) disable iff (!RST_N_I)
        LINK_DEAD_O |=> LINK_DEAD_O && !UART_TX_VALID_O)
        else $error("dead link resumed");
endmodule // hrlp_rx

// ### bench/hrlp_peer.sv
`timescale 1ns/100ps
// ============================================================
// Remote sender: streams characters and collects the answers
// ============================================================
module hrlp_peer (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       slow_i,
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i,
    output logic      [7:0] rx_data_o,
    output logic            rx_err_o,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    input  wire logic [7:0] tx_data_i
);
    logic [8:0] txq[$];
    logic [7:0] ans[$];
    logic [1:0] div;

    // Bit 8 flags a framing fault on that character
    task automatic put(input logic [8:0] c);
        txq.push_back(c);
    endtask

    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
        rx_err_o   = 1'b0;
        tx_ready_o = 1'b0;
        div        = 2'h0;
    end

    always @(posedge clk_i) begin
        div        <= div + 2'h1;
        // Answers drain on their own line
        tx_ready_o <= !slow_i || (div == 2'h0);
        if (tx_valid_i && tx_ready_o) begin
            ans.push_back(tx_data_i);
        end
        if (!rst_n_i) begin
            rx_valid_o <= 1'b0;
        end else if (!rx_valid_o || rx_ready_i) begin
            if (txq.size() > 0) begin
                // Caller supplies top bit zero unless told otherwise
                {rx_err_o, rx_data_o} <= txq.pop_front();
                rx_valid_o            <= 1'b1;
            end else begin
                // Stale data must not look like a held character
                rx_valid_o <= 1'b0;
                rx_err_o   <= 1'b0;
                rx_data_o  <= ~rx_data_o;
            end
        end
    end
endmodule // hrlp_peer

// ### bench/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import hrlp_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        slow = 1'b0;
    logic        mem_rdy = 1'b0;
    logic        exp_mem = 1'b0;
    logic        top = 1'b0;
    logic        rx_valid, rx_ready, rx_err, tx_valid, tx_ready;
    logic [7:0]  rx_data, tx_data, mem_data;
    logic [15:0] mem_addr;
    logic        mem_valid, done, cnt_err, dead;
    logic [23:0] wq[$];
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;

    always #2 clk = ~clk;

    hrlp_peer u_peer (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
        .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
        .rx_err_o(rx_err), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
        .tx_data_i(tx_data));

    hrlp_rx #(.TMO_CYC(32'd200), .BUF_DEPTH(2)) u_dut (
        .CLK_I(clk), .RST_N_I(rst_n), .UART_RX_VALID_I(rx_valid),
        .UART_RX_READY_O(rx_ready), .UART_RX_DATA_I(rx_data),
        .UART_RX_ERR_I(rx_err), .UART_TX_VALID_O(tx_valid),
        .UART_TX_READY_I(tx_ready), .UART_TX_DATA_O(tx_data),
        .MEM_VALID_O(mem_valid), .MEM_READY_I(mem_rdy),
        .MEM_ADDR_O(mem_addr), .MEM_DATA_O(mem_data),
        .MEM_EXPANDED_I(exp_mem), .DONE_O(done),
        .REC_COUNT_ERR_O(cnt_err), .LINK_DEAD_O(dead));

    // ========================================================
    // Memory side stalls half the time to fill the buffer
    // ========================================================
    always @(posedge clk) begin
        cyc     <= cyc + 1;
        mem_rdy <= cyc[2];
        if (mem_valid && mem_rdy) begin
            wq.push_back({mem_addr, mem_data});
        end
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] hx(input logic [3:0] v);
        return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
    endfunction

    task automatic pc(input logic [7:0] c);
        u_peer.put({1'b0, c | {top, 7'h00}});
    endtask

    task automatic pb(input logic [7:0] b);
        pc(hx(b[7:4]));
        pc(hx(b[3:0]));
    endtask

    task automatic get_ans(output logic [7:0] c);
        int n;
        n = 0;
        while (u_peer.ans.size() == 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        #1;
        c = (u_peer.ans.size() > 0) ? u_peer.ans.pop_front() : 8'hXX;
    endtask

    // ========================================================
    // One record: dl/dr corrupt the checks, he faults the start
    // ========================================================
    task automatic rec(input logic [7:0] nf, input logic [15:0] a,
                       input logic [7:0] nd, input logic [7:0] dl,
                       input logic [15:0] dr, input logic he,
                       input logic [7:0] exp);
        logic [7:0]  ac;
        logic [15:0] rc;
        logic [7:0]  d;
        logic [7:0]  got;
        int          k;
        ac = 8'h00 + nf[7:4] + nf[3:0] + a[15:12] + a[11:8] + a[7:4] + a[3:0];
        rc = {8'h00, nf} + {8'h00, a[15:8]} + {8'h00, a[7:0]};
        wq.delete();
        if (he) begin
            u_peer.put({1'b1, CH_SEMI});
        end else begin
            pc(CH_SEMI);
        end
        pb(nf);
        pb(a[15:8]);
        pb(a[7:0]);
        pb(ac + dl);
        for (k = 0; k < nd; k++) begin
            d  = 8'hC0 + k[7:0];
            rc = rc + {8'h00, d};
            pb(d);
        end
        rc = rc + dr;
        pb(rc[15:8]);
        pb(rc[7:0]);
        pc(CH_CR);
        pc(CH_LF);
        get_ans(got);
        check({16'h0, got}, {16'h0, exp});
        repeat (16) @(posedge clk);
        if (exp == CH_ACK) begin
            check(24'(wq.size()), {16'h0, nd});
            for (k = 0; k < nd && k < wq.size(); k++) begin
                check(wq[k], {a + k[15:0], 8'hC0 + k[7:0]});
            end
        end else if (exp == NAK_ACHK || exp == NAK_ANY) begin
            check(24'(wq.size()), 24'h0);
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check({tx_valid, mem_valid, done, cnt_err, dead}, 24'h0);
        slow <= 1'b1;
        rec(8'h02, 16'h0010, 8'h02, 8'h00, 16'h0, 1'b0, CH_ACK);
        slow <= 1'b0;
        rec(8'h20, 16'h1FE0, 8'h20, 8'h00, 16'h0, 1'b0, CH_ACK);
        rec(8'h01, 16'h0040, 8'h01, 8'h01, 16'h0, 1'b0, NAK_ACHK);
        rec(8'h01, 16'h0040, 8'h01, 8'h00, 16'h1, 1'b0, NAK_RCHK);
        rec(8'h03, 16'h0040, 8'h02, 8'h00, 16'h0, 1'b0, NAK_COUNT);
        rec(8'h21, 16'h0100, 8'h21, 8'h00, 16'h0, 1'b0, NAK_COUNT);
        rec(8'h01, 16'h2000, 8'h01, 8'h00, 16'h0, 1'b0, NAK_ANY);
        rec(8'h01, 16'h0040, 8'h01, 8'h00, 16'h0, 1'b1, NAK_CHAR);
        exp_mem <= 1'b1;
        top = 1'b1;
        rec(8'h02, 16'h7FFE, 8'h02, 8'h00, 16'h0, 1'b0, CH_ACK);
        top = 1'b0;
        rec(8'h00, 16'h0003, 8'h00, 8'h00, 16'h0, 1'b0, CH_ACK);
        check({23'h0, done}, 24'h1);
        rec(8'h00, 16'h0007, 8'h00, 8'h00, 16'h0, 1'b0, NAK_RECS);
        check({22'h0, cnt_err, done}, 24'h2);
        begin : idle_out
            logic [7:0] got;
            get_ans(got);
            check({16'h0, got}, {16'h0, NAK_TMO});
            repeat (600) @(posedge clk);
            #1;
            check({23'h0, dead}, 24'h1);
            check(24'(u_peer.ans.size()), 24'h0);
        end
        conclude();
    end
endmodule // tb_top
